/* design/pspl_pkg.sv */
/*
 pspl_pkg: shared timing constants, widths and state encodings for the
 pixel serial pulse link receiver, word latch and regenerator.
 assumes a single 200 MHz system clock; threshold, output high times and frame gap are converted to cycles here.
*/
// How it works
// - bit time 1.25 us, plus or minus 300 ns
// - low for 300 us ends frame, relatch
// - word holds 24 bits, three 8-bit channels
// - order green, red, blue, msb first
// - later words regenerated and passed downstream
// - keep first 24 bits, forward the rest
// - silent primary input and a backup rising edge: switch to backup for good
package pspl_pkg;

   // clock period
   localparam int CLK_PERIOD_NS = 5;

   // link timing, figures as printed
   localparam int BIT_TIME_NS = 1250;
   localparam int BIT_TOL_NS = 300;
   localparam int ZERO_HIGH_MIN_NS = 300;
   localparam int ZERO_HIGH_MAX_NS = 450;
   localparam int ONE_HIGH_MIN_NS = 750;
   localparam int ONE_HIGH_MAX_NS = 1000;
   localparam int LOW_MIN_NS = 300;
   localparam int LOW_MAX_US = 100;
   localparam int FRAME_GAP_US = 300;

   // decision point sits midway between the two high-time windows
   localparam int THRESH_NS = (ZERO_HIGH_MAX_NS + ONE_HIGH_MIN_NS) / 2;
   localparam int THRESH_CYC = (THRESH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // regenerated high times: centre of each printed window
   localparam int ZERO_OUT_NS = (ZERO_HIGH_MIN_NS + ZERO_HIGH_MAX_NS) / 2;
   localparam int ONE_OUT_NS = (ONE_HIGH_MIN_NS + ONE_HIGH_MAX_NS) / 2;
   localparam int ZERO_OUT_CYC = ZERO_OUT_NS / CLK_PERIOD_NS;
   localparam int ONE_OUT_CYC = ONE_OUT_NS / CLK_PERIOD_NS;

   // frame gap, a least time, rounded up
   localparam int FRAME_GAP_CYC = (FRAME_GAP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // word layout
   localparam int WORD_BITS = 24;
   localparam int CHAN_BITS = 8;
   localparam int GREEN_LSB = 16;
   localparam int RED_LSB = 8;
   localparam int BLUE_LSB = 0;

   // counter widths
   localparam int GAP_CNT_W = 17;
   localparam int PHASE_CNT_W = 8;
   localparam int BIT_CNT_W = 5;

   // reset values
   localparam logic [CHAN_BITS-1:0] CHAN_RST = 8'h00;

   // word handling mode
   typedef enum logic [0:0]
   {
      MODE_LATCH = 1'b0,
      MODE_FWD = 1'b1
   } pspl_mode_type;

   // regenerator output state
   typedef enum logic [0:0]
   {
      OUT_IDLE = 1'b0,
      OUT_HIGH = 1'b1
   } pspl_out_type;

endpackage

/* design/pspl_bitrx.sv */
/*
 pspl_bitrx: measures each pulse on the selected serial line, gives one
 decision strobe per bit at a fixed delay after the rising edge, and a
 strobe when the line has stayed low for a whole frame gap.
 assumes the line is synchronous to CLK; CE low freezes all state.
*/
`timescale 1ns/100ps
module pspl_bitrx
#(
   parameter int GAP_CYC = pspl_pkg::FRAME_GAP_CYC
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic line,
   output logic bit_stb,
   output logic bit_val,
   output logic gap_stb
);

   localparam int THR = pspl_pkg::THRESH_CYC;

   logic line_prev_r; // line one cycle ago
   logic busy_r; // measuring a pulse
   logic fell_r; // line dropped before the threshold
   logic [pspl_pkg::PHASE_CNT_W-1:0] phase_r; // cycles since rising edge
   logic [pspl_pkg::GAP_CNT_W-1:0] low_r; // cycles of continuous low
   logic gap_seen_r; // gap already reported for this idle stretch
   logic rise;

   assign rise = line && !line_prev_r;

   ////////////////////////////////////////////////////////////////////////
   // edge history
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         line_prev_r <= 1'b0;
      else if (ce)
         line_prev_r <= line;
   end

   ////////////////////////////////////////////////////////////////////////
   // pulse measurement: decide at the threshold whether the line is still high
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         busy_r <= 1'b0;
         fell_r <= 1'b0;
         phase_r <= '0;
         bit_stb <= 1'b0;
         bit_val <= 1'b0;
      end
      else if (ce)
      begin
         bit_stb <= 1'b0;
         if (rise && !busy_r)
         begin
            // new bit: count from the edge
            busy_r <= 1'b1;
            fell_r <= 1'b0;
            phase_r <= '0;
         end
         else if (busy_r)
         begin
            if (!line)
               fell_r <= 1'b1;
            if (phase_r == pspl_pkg::PHASE_CNT_W'(THR - 2))
            begin
               // fixed delay for both kinds keeps the regenerated period intact
               busy_r <= 1'b0;
               bit_stb <= 1'b1;
               bit_val <= line && !fell_r;
            end
            else
               phase_r <= phase_r + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // frame gap: one strobe per long low stretch
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         low_r <= '0;
         gap_seen_r <= 1'b0;
         gap_stb <= 1'b0;
      end
      else if (ce)
      begin
         gap_stb <= 1'b0;
         if (line)
         begin
            low_r <= '0;
            gap_seen_r <= 1'b0;
         end
         else if (low_r == pspl_pkg::GAP_CNT_W'(GAP_CYC - 1) && !gap_seen_r)
         begin
            gap_stb <= 1'b1;
            gap_seen_r <= 1'b1;
         end
         else if (!gap_seen_r)
            low_r <= low_r + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn || !ce);

   sequence s_pulse_start;
      rise && !busy_r;
   endsequence

   a_decide_delay: assert property (s_pulse_start |-> ##THR bit_stb)
      else $error("bit decision not at threshold delay");

   a_one_needs_high: assert property (bit_stb && bit_val |-> $past(line))
      else $error("one decided while line was low");

   a_gap_low: assert property (gap_stb |-> $past(!line) && !$past(gap_seen_r))
      else $error("gap strobe without low line");

endmodule

/* design/pspl_link.sv */
/*
 pspl_link: one pixel of a daisy chain. keeps the first 24-bit word of each
 frame as its colour, regenerates every later bit toward the next pixel, and
 falls back to the backup input when the primary input stays silent and the backup input then shows a rising edge.
 assumes DIN and BACKUP_SERIAL_IN are synchronous to CLK; CE low freezes all.
*/
`timescale 1ns/100ps
module pspl_link
#(
   parameter int GAP_CYC = pspl_pkg::FRAME_GAP_CYC,
   parameter int LOSS_CYC = pspl_pkg::FRAME_GAP_CYC
)
(
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic CE,
   input wire logic DIN,
   input wire logic BACKUP_SERIAL_IN,
   output logic DOUT,
   output logic [pspl_pkg::CHAN_BITS-1:0] GREEN,
   output logic [pspl_pkg::CHAN_BITS-1:0] RED,
   output logic [pspl_pkg::CHAN_BITS-1:0] BLUE,
   output logic WORD_VALID,
   output logic ON_BACKUP
);

   localparam int ZC = pspl_pkg::ZERO_OUT_CYC;
   localparam int OC = pspl_pkg::ONE_OUT_CYC;

   logic use_backup_r; // sticky source select
   logic line; // selected serial input
   logic bsi_prev_r; // backup input one cycle ago
   logic [pspl_pkg::GAP_CNT_W-1:0] quiet_r; // cycles since primary was high
   logic bit_stb;
   logic bit_val;
   logic gap_stb;
   logic [pspl_pkg::BIT_CNT_W-1:0] bit_cnt_r; // bits kept this frame
   pspl_pkg::pspl_mode_type mode;
   logic [pspl_pkg::WORD_BITS-1:0] shift_r; // incoming word
   pspl_pkg::pspl_out_type out_state_r;
   logic [pspl_pkg::PHASE_CNT_W-1:0] out_cnt_r; // cycles of regenerated high
   logic [pspl_pkg::PHASE_CNT_W-1:0] out_len_r; // high length for this bit
   logic primary_lost;

   // word mode follows from how many bits this frame has kept
   assign mode = (bit_cnt_r == pspl_pkg::BIT_CNT_W'(pspl_pkg::WORD_BITS))
                 ? pspl_pkg::MODE_FWD : pspl_pkg::MODE_LATCH;
   assign line = use_backup_r ? BACKUP_SERIAL_IN : DIN;
   assign primary_lost = (quiet_r == pspl_pkg::GAP_CNT_W'(LOSS_CYC));
   assign ON_BACKUP = use_backup_r;

   ////////////////////////////////////////////////////////////////////////
   // bit receiver on the selected input
   pspl_bitrx #(.GAP_CYC(GAP_CYC)) u_rx
   (
      .clk(CLK),
      .rstn(RSTN),
      .ce(CE),
      .line(line),
      .bit_stb(bit_stb),
      .bit_val(bit_val),
      .gap_stb(gap_stb)
   );

   ////////////////////////////////////////////////////////////////////////
   // primary watchdog: saturating count of cycles without a high level
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         quiet_r <= '0;
         bsi_prev_r <= 1'b0;
      end
      else if (CE)
      begin
         bsi_prev_r <= BACKUP_SERIAL_IN;
         if (DIN)
            quiet_r <= '0;
         else if (!primary_lost)
            quiet_r <= quiet_r + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // source select: only reset brings the primary input back
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
         use_backup_r <= 1'b0;
      else if (CE)
      begin
         // backup must show activity, so a dead chain does not flip it
         if (primary_lost && BACKUP_SERIAL_IN && !bsi_prev_r)
            use_backup_r <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bit counting and word capture
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         bit_cnt_r <= '0;
         shift_r <= '0;
      end
      else if (CE)
      begin
         if (gap_stb)
            bit_cnt_r <= '0;
         else if (bit_stb && mode == pspl_pkg::MODE_LATCH)
         begin
            // msb arrives first, so shift toward the top
            shift_r <= {shift_r[pspl_pkg::WORD_BITS-2:0], bit_val};
            bit_cnt_r <= bit_cnt_r + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // colour outputs: updated once per frame, on the last kept bit
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         GREEN <= pspl_pkg::CHAN_RST;
         RED <= pspl_pkg::CHAN_RST;
         BLUE <= pspl_pkg::CHAN_RST;
         WORD_VALID <= 1'b0;
      end
      else if (CE)
      begin
         if (bit_stb && bit_cnt_r == pspl_pkg::BIT_CNT_W'(pspl_pkg::WORD_BITS - 1))
         begin
            // green first, red second, blue last
            // shift_r still lacks the last bit, so every field sits one place low
            GREEN <= shift_r[pspl_pkg::GREEN_LSB-1 +: pspl_pkg::CHAN_BITS];
            RED <= shift_r[pspl_pkg::RED_LSB-1 +: pspl_pkg::CHAN_BITS];
            BLUE <= {shift_r[pspl_pkg::CHAN_BITS-2:0], bit_val};
            WORD_VALID <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // regenerator: fresh pulse with nominal high time for each forwarded bit
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         out_state_r <= pspl_pkg::OUT_IDLE;
         out_cnt_r <= '0;
         out_len_r <= '0;
         DOUT <= 1'b0;
      end
      else if (CE)
      begin
         case (out_state_r)
            pspl_pkg::OUT_IDLE:
            begin
               // same delay for every bit keeps the bit period unchanged
               if (bit_stb && mode == pspl_pkg::MODE_FWD)
               begin
                  out_state_r <= pspl_pkg::OUT_HIGH;
                  out_len_r <= bit_val ? pspl_pkg::PHASE_CNT_W'(OC) : pspl_pkg::PHASE_CNT_W'(ZC);
                  out_cnt_r <= '0;
                  DOUT <= 1'b1;
               end
            end
            pspl_pkg::OUT_HIGH:
            begin
               if (out_cnt_r == out_len_r - 1'b1)
               begin
                  // low phase lasts until the next bit decision
                  out_state_r <= pspl_pkg::OUT_IDLE;
                  DOUT <= 1'b0;
               end
               else
                  out_cnt_r <= out_cnt_r + 1'b1;
            end
            default:
            begin
               out_state_r <= pspl_pkg::OUT_IDLE;
               DOUT <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN || !CE);

   sequence s_fwd_bit;
      bit_stb && mode == pspl_pkg::MODE_FWD && out_state_r == pspl_pkg::OUT_IDLE;
   endsequence

   a_pulse_width: assert property ($fell(DOUT) |-> $past(out_cnt_r) == (ZC - 1) || $past(out_cnt_r) == (OC - 1))
      else $error("regenerated high time wrong");

   a_zero_pulse: assert property (s_fwd_bit and !bit_val |=> DOUT [*8])
      else $error("zero pulse ended too early");

   a_fwd_starts: assert property (s_fwd_bit |=> DOUT && out_cnt_r == 0)
      else $error("forwarded bit not regenerated");

   a_latch_quiet: assert property (mode == pspl_pkg::MODE_LATCH && out_state_r == pspl_pkg::OUT_IDLE
                                   |=> !DOUT)
      else $error("output active while word is being kept");

   a_word_order: assert property (bit_stb && bit_cnt_r == 5'h17 |=> WORD_VALID
                                  && BLUE[0] == $past(bit_val) && GREEN == $past(shift_r[22:15]))
      else $error("colour word assembled wrongly");

   a_gap_relatch: assert property (gap_stb |=> bit_cnt_r == 0)
      else $error("frame gap did not restart word");

   a_backup_sticky: assert property (use_backup_r |=> use_backup_r)
      else $error("backup select dropped");

   a_backup_cause: assert property ($rose(use_backup_r) |-> $past(primary_lost))
      else $error("switched to backup while primary alive");

endmodule

/* testbench/pspl_drv.sv */
/*
 pspl_drv: upstream driver model for one serial input of the pixel link.
 sends bits with random high times inside the legal windows, frame gaps
 and single raw pulses. assumes clk is the 200 MHz system clock.
*/
`timescale 1ns/100ps
module pspl_drv
(
   input wire logic clk,
   output logic line
);
   // timing randomness, repeatable from a fixed start
   int seed = 79;
   // line idles low, as between frames
   initial line = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // hold one level for n cycles, changed 1 ns after the edge
   task put(input logic v, input int n);
      @(posedge clk);
      #1;
      line = v;
      repeat (n - 1) @(posedge clk);
   endtask

   // one bit: period fixed at 250 cycles, so low time follows high time
   task send_bit(input logic b, input logic corner);
      int hi;
      hi = b ? 150 + ($unsigned($random(seed)) % 41) : 60 + ($unsigned($random(seed)) % 31);
      // corner: the high times nearest the decision point
      if (corner)
      begin
         hi = b ? 150 : 90;
      end
      put(1'b1, hi);
      put(1'b0, 250 - hi);
   endtask

   // the first n bits of a word, most significant first
   task send_word(input logic [23:0] w, input int n, input logic corner);
      for (int i = 23; i > 23 - n; i--)
      begin
         send_bit(w[i], corner);
      end
   endtask

   // long low level ends the frame
   task gap(input int n);
      put(1'b0, n);
   endtask
endmodule

/* testbench/pspl_link_tb.sv */
/*
 pspl_link_tb: self-checking bench for one pixel. two driver models feed
 the primary and backup inputs; a monitor decodes the regenerated output.
 assumes shortened gap and loss counts of 400 cycles; CE held high except during the clock enable step.
*/
`timescale 1ns/100ps
module pspl_link_tb;
   localparam int GAP = 400;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic din;
   logic bsi;
   logic dout;
   logic [7:0] green;
   logic [7:0] red;
   logic [7:0] blue;
   logic word_valid;
   logic on_backup;
   int n_mismatch = 0;
   int n_compared = 0;
   int seed = 79;
   int cyc = 0;
   // high length of the pulse now on the output
   int hi_cnt = 0;
   // count and shift register of forwarded bits
   int n_fwd = 0;
   logic [23:0] fwd_w = 24'h000000;
   logic [23:0] w_a;
   logic [23:0] w_b;

   always #2.5 clk = ~clk;

   pspl_link #(.GAP_CYC(GAP), .LOSS_CYC(GAP)) u_pspl_link (.CLK(clk), .RSTN(rstn), .CE(ce), .DIN(din),
      .BACKUP_SERIAL_IN(bsi), .DOUT(dout), .GREEN(green), .RED(red), .BLUE(blue), .WORD_VALID(word_valid),
      .ON_BACKUP(on_backup));
   pspl_drv u_drv_a (.clk(clk), .line(din));
   pspl_drv u_drv_b (.clk(clk), .line(bsi));

   ////////////////////////////////////////////////////////////////////////////
   task chk(input logic [23:0] seen, input logic [23:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task final_report();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // regenerated pulse length owed for a decoded bit
   function automatic logic [23:0] exp_width(input logic b);
      return b ? 24'(pspl_pkg::ONE_OUT_CYC) : 24'(pspl_pkg::ZERO_OUT_CYC);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // hang guard: a run this long has stalled somewhere
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 90000)
      begin
         n_mismatch++;
         final_report();
      end
   end

   // output monitor; long pulses read as ones
   always @(posedge clk)
   begin
      if (dout === 1'b1)
         hi_cnt <= hi_cnt + 1;
      else if (hi_cnt != 0)
      begin
         chk(24'(hi_cnt), exp_width(hi_cnt > 125));
         fwd_w <= {fwd_w[22:0], hi_cnt > 125};
         n_fwd <= n_fwd + 1;
         hi_cnt <= 0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // send on either input; word b follows only when two is set
   task frame(input logic bk, input logic [23:0] a, input logic [23:0] b, input logic two, input logic cor);
      int f0;
      f0 = n_fwd;
      if (bk)
      begin
         u_drv_b.send_word(a, 24, cor);
         if (two) u_drv_b.send_word(b, 24, cor);
         u_drv_b.gap(GAP + 100);
      end
      else
      begin
         u_drv_a.send_word(a, 24, cor);
         if (two) u_drv_a.send_word(b, 24, cor);
         u_drv_a.gap(GAP + 100);
      end
      // let the edge's updates land before looking
      @(negedge clk);
      chk({green, red, blue}, a);
      chk({23'h000000, word_valid}, 24'h000001);
      chk(24'(n_fwd - f0), two ? 24'h000018 : 24'h000000);
      if (two) chk(fwd_w, b);
   endtask

   initial
   begin
      repeat (20) @(posedge clk);
      #1;
      rstn = 1'b1;
      // cleared state after reset
      chk({green, red, blue}, 24'h000000);
      chk({22'h000000, word_valid, on_backup}, 24'h000000);
      // random frames, the last with high times at the threshold edges
      for (int k = 0; k < 3; k++)
      begin
         w_a = 24'($random(seed));
         w_b = 24'($random(seed));
         frame(1'b0, w_a, w_b, 1'b1, k == 2);
      end
      // partial word cut by a gap is thrown away
      u_drv_a.send_word(24'hFFFFFF, 10, 1'b0);
      u_drv_a.gap(GAP + 100);
      w_a = 24'($random(seed));
      frame(1'b0, w_a, w_a, 1'b0, 1'b0);
      chk({23'h000000, on_backup}, 24'h000000);
      // primary silent: a backup edge selects the backup for good
      u_drv_b.put(1'b1, 100);
      u_drv_b.gap(GAP + 100);
      @(negedge clk);
      chk({23'h000000, on_backup}, 24'h000001);
      w_a = 24'($random(seed));
      w_b = 24'($random(seed));
      frame(1'b1, w_a, w_b, 1'b1, 1'b0);
      // the primary is no longer heard
      u_drv_a.send_word(~w_a, 24, 1'b0);
      u_drv_a.gap(GAP + 100);
      @(negedge clk);
      chk({green, red, blue}, w_a);
      chk({23'h000000, on_backup}, 24'h000001);
      // clock enable low: a whole word on the selected input must go unseen
      @(posedge clk);
      #1;
      ce = 1'b0;
      u_drv_b.send_word(~w_b, 24, 1'b0);
      @(posedge clk);
      #1;
      ce = 1'b1;
      u_drv_b.gap(GAP + 100);
      @(negedge clk);
      chk({green, red, blue}, w_a);
      final_report();
   end
endmodule
